// ==== hdl/lbps_seq.sv ====
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/10ps
module lbps_seq
  import lbps_pkg::*;
#(
  parameter int BLANK_OSC = OLP_BLANK_OSC
)
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              osc_clk,
  input  wire logic              pwm_dim_input,
  input  wire lbps_cmp_t         cmp_in,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata_q,
  output logic                   irq_q,
  output logic                   boost_gate_q,
  output logic                   dim_gate_q,
  output logic                   ea_connect_q,
  output logic                   fault_output_q,
  output logic                   fault_output_oe_q
);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // two-flop synchronisers
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic              osc_prev_q;
  lbps_cmp_t         cmp_s;
  logic              dim_s;
  logic              osc_s;

  assign raw = {osc_clk, pwm_dim_input, cmp_in};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end
        else if (clk_en)
        begin
          sync1_q[gi] <= raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign cmp_s = lbps_cmp_t'(sync2_q[4:0]);
  assign dim_s = sync2_q[5];
  assign osc_s = sync2_q[6];

  // oscillator edges
  wire osc_rise = osc_s & ~osc_prev_q;
  wire osc_fall = ~osc_s & osc_prev_q;

  // registers
  logic [DATA_W-1:0] ctrl_q;
  logic [NUM_EV-1:0] stat_q;
  logic [NUM_EV-1:0] mask_q;

  // protection state
  logic        armed_q;
  logic        ovp_q;
  logic        force_q;
  logic        fault_q;
  logic        ocp_off_q;
  logic [7:0]  olp_cnt_q;
  logic [13:0] blank_cnt_q;
  logic [5:0]  ocp_cnt_q;
  logic [7:0]  ar_cnt_q;
  logic [3:0]  leb_cnt_q;

  wire run = ctrl_q[CTRL_RUN];
  wire eff_dim = dim_s | force_q;
  wire olp_cond = armed_q & eff_dim & cmp_s.fb_low;
  wire drive_ok = run & eff_dim & ~ovp_q & ~ocp_off_q;
  wire leb_done = (leb_cnt_q == 4'(LEB_CYC));
  wire cs_trip = boost_gate_q & leb_done & cmp_s.cs_over;
  wire force_hit = (olp_cnt_q == 8'(OLP_FORCE_CYC));
  wire blank_hit = (blank_cnt_q == 14'(BLANK_OSC - 1));
  wire ocp_hit = (ocp_cnt_q == 6'(OCP_DELAY_CYC - 1));
  wire ar_hit = (ar_cnt_q == 8'(AR_OSC - 1));
  wire ovp_set = cmp_s.ovp_trip & ~ovp_q;

  // events
  logic [NUM_EV-1:0] ev;
  assign ev[EV_OVP] = ovp_set;
  assign ev[EV_OCP] = cmp_s.fb_ocp & ~ocp_off_q & ocp_hit;
  assign ev[EV_OLP] = olp_cond & ~ovp_q & osc_rise & blank_hit & ~fault_q;
  assign ev[EV_CS]  = cs_trip;

  // bus decode
  wire wr_ctrl = reg_wr & hit(reg_addr, CTRL_OFS);
  wire wr_stat = reg_wr & hit(reg_addr, STAT_OFS);
  wire wr_mask = reg_wr & hit(reg_addr, MASK_OFS);
  wire [NUM_EV-1:0] w1c = wr_stat ? reg_wdata[NUM_EV-1:0] : '0;
  wire [NUM_EV-1:0] stat_d = (stat_q & ~w1c) | ev;

  logic [DATA_W-1:0] live;
  assign live = {2'b00, eff_dim, armed_q, fault_q, force_q,
                 ocp_off_q, ovp_q};

  logic [DATA_W-1:0] rd_mux;
  assign rd_mux =
    hit(reg_addr, CTRL_OFS) ? ctrl_q :
    hit(reg_addr, STAT_OFS) ? {{(DATA_W-NUM_EV){1'b0}}, stat_q} :
    hit(reg_addr, MASK_OFS) ? {{(DATA_W-NUM_EV){1'b0}}, mask_q} :
    hit(reg_addr, LIVE_OFS) ? live :
    '0;

  // register file and interrupt
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_q      <= CTRL_RST;
      stat_q      <= '0;
      mask_q      <= MASK_RST[NUM_EV-1:0];
      irq_q       <= 1'b0;
      reg_rdata_q <= '0;
    end
    else if (clk_en)
    begin
      if (wr_ctrl)
        ctrl_q <= reg_wdata;
      if (wr_mask)
        mask_q <= reg_wdata[NUM_EV-1:0];
      stat_q      <= stat_d;
      irq_q       <= |(stat_d & mask_q);
      reg_rdata_q <= reg_rd ? rd_mux : '0;
    end
  end

  // oscillator edge history
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      osc_prev_q <= 1'b0;
    else if (clk_en)
      osc_prev_q <= osc_s;
  end

  // arm on first dim high
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      armed_q <= 1'b0;
    else if (clk_en && dim_s)
      armed_q <= 1'b1;
  end

  // over-voltage with hysteresis
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ovp_q <= 1'b0;
    else if (clk_en)
    begin
      if (cmp_s.ovp_trip)
        ovp_q <= 1'b1;
      else if (cmp_s.ovp_below)
        ovp_q <= 1'b0;
    end
  end

  // open string: forced dim after 5 us
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      olp_cnt_q <= '0;
      force_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!olp_cond)
      begin
        olp_cnt_q <= '0;
        force_q   <= 1'b0;
      end
      else if (force_hit)
        force_q <= 1'b1;
      else
        olp_cnt_q <= olp_cnt_q + 8'h01;
    end
  end

  // open string: blanking in oscillator cycles
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      blank_cnt_q <= '0;
      fault_q     <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!olp_cond)
        blank_cnt_q <= '0;
      else if (osc_rise && !ovp_q)
      begin
        if (blank_hit)
          fault_q <= 1'b1;
        else
          blank_cnt_q <= blank_cnt_q + 14'h0001;
      end
    end
  end

  // led over-current: delay, shutdown, auto restart
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ocp_cnt_q <= '0;
      ar_cnt_q  <= '0;
      ocp_off_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (ocp_off_q)
      begin
        ocp_cnt_q <= '0;
        if (osc_rise)
        begin
          if (ar_hit)
            ocp_off_q <= 1'b0;
          else
            ar_cnt_q <= ar_cnt_q + 8'h01;
        end
      end
      else if (!cmp_s.fb_ocp)
        ocp_cnt_q <= '0;
      else if (ocp_hit)
      begin
        ocp_off_q <= 1'b1;
        ar_cnt_q  <= '0;
      end
      else
        ocp_cnt_q <= ocp_cnt_q + 6'h01;
    end
  end

  // boost switch with leading-edge blanking
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      boost_gate_q <= 1'b0;
      leb_cnt_q    <= '0;
    end
    else if (clk_en)
    begin
      if (!drive_ok || cs_trip || osc_fall)
        boost_gate_q <= 1'b0;
      else if (osc_rise)
      begin
        boost_gate_q <= 1'b1;
        leb_cnt_q    <= '0;
      end
      else if (boost_gate_q && !leb_done)
        leb_cnt_q <= leb_cnt_q + 4'h1;
    end
  end

  // dim switch, error amp link, fault pin
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dim_gate_q        <= 1'b0;
      ea_connect_q      <= 1'b0;
      fault_output_q    <= 1'b0;
      fault_output_oe_q <= 1'b1;
    end
    else if (clk_en)
    begin
      dim_gate_q        <= drive_ok;
      ea_connect_q      <= run & eff_dim;
      fault_output_q    <= 1'b0;
      fault_output_oe_q <= ~fault_q;
    end
  end

endmodule

// ==== hdl/lbps_pkg.sv ====
package lbps_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int LEB_NS        = 300;
  localparam int LEB_CYC       = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OLP_FORCE_NS  = 5000;
  localparam int OLP_FORCE_CYC = OLP_FORCE_NS / CLK_PERIOD_NS;
  localparam int OCP_DELAY_NS  = 1000;
  localparam int OCP_DELAY_CYC = OCP_DELAY_NS / CLK_PERIOD_NS;
  localparam int OLP_BLANK_OSC = 8192;
  localparam int AR_OSC        = 128;
  localparam int SYNC_W        = 7;

  // register bus
  localparam int        ADDR_W   = 4;
  localparam int        DATA_W   = 8;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] MASK_OFS = 4'h8;
  localparam logic [3:0] LIVE_OFS = 4'hC;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] MASK_RST = 8'h00;

  // control bit
  localparam int CTRL_RUN = 0;

  // event bits, shared by status and mask
  localparam int NUM_EV = 4;
  localparam int EV_OVP = 0;
  localparam int EV_OCP = 1;
  localparam int EV_OLP = 2;
  localparam int EV_CS  = 3;

  // live state bits
  localparam int LV_OVP   = 0;
  localparam int LV_OCP   = 1;
  localparam int LV_FORCE = 2;
  localparam int LV_FAULT = 3;
  localparam int LV_ARMED = 4;
  localparam int LV_DIM   = 5;

  typedef struct packed {
    logic cs_over;
    logic fb_low;
    logic ovp_trip;
    logic ovp_below;
    logic fb_ocp;
  } lbps_cmp_t;

endpackage

// ==== tb/lbps_seq_asserts.sv ====
`timescale 1ns/10ps
module lbps_seq_asserts
  import lbps_pkg::*;
#(
  parameter int BLANK_OSC = 16
)
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  input wire logic       osc_clk,
  input wire lbps_cmp_t  cmp_in,
  input wire logic       boost_gate_q,
  input wire logic       dim_gate_q,
  input wire logic       ea_connect_q,
  input wire logic       fault_output_q,
  input wire logic       fault_output_oe_q
);
  logic [5:0] ocp_n_q;
  logic [5:0] cs_n_q;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // consecutive cycles of a held condition, saturating
  always_ff @(posedge clk)
  begin
    ocp_n_q <= (sys_rst || !(clk_en && cmp_in.fb_ocp)) ? 6'h00 :
               ocp_n_q + {5'h00, ~&ocp_n_q};
    cs_n_q  <= (sys_rst || !(clk_en && cmp_in.cs_over && osc_clk)) ?
               6'h00 : cs_n_q + {5'h00, ~&cs_n_q};
  end
  sequence ovp_held;
    (clk_en && cmp_in.ovp_trip && !cmp_in.ovp_below)[*6];
  endsequence
  sequence ovp_band;
    (clk_en && !cmp_in.ovp_below)[*4];
  endsequence
  a_ovp_gates_off: assert property (ovp_held |-> !dim_gate_q && !boost_gate_q)
    else $error("gates on during output trip");
  a_ovp_hyst_hold: assert property (ovp_held ##1 ovp_band |-> !dim_gate_q)
    else $error("trip state left above lower level");
  a_ocp_shuts_off: assert property (ocp_n_q == 6'h38 |-> !dim_gate_q && !boost_gate_q)
    else $error("drives still on after over-current");
  a_cs_ends_on: assert property (cs_n_q == 6'h18 |-> !boost_gate_q)
    else $error("on-time not ended by switch current");
  a_boost_needs_dim: assert property (boost_gate_q |-> dim_gate_q)
    else $error("boost on without dim drive");
  a_dim_links_ea: assert property (dim_gate_q |-> ea_connect_q)
    else $error("error amp not linked while dim on");
  a_fault_pin_zero: assert property (fault_output_q == 1'b0)
    else $error("fault data not low");
  a_fault_stays: assert property (!fault_output_oe_q |=> !fault_output_oe_q)
    else $error("fault released before reset");
  a_fault_from_open: assert property ($fell(fault_output_oe_q) |-> $past(cmp_in.fb_low, 4))
    else $error("fault without open string");
endmodule

// ==== tb/lbps_stage_model.sv ====
`timescale 1ns/10ps
module lbps_stage_model
  import lbps_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       fault_pin,
  input  wire logic [4:0] mode,
  output logic            osc_clk,
  output lbps_cmp_t       cmp
);
  logic [5:0] osc_q;
  // system removes power on fault, so the oscillator stops
  always_ff @(posedge clk)
  begin
    osc_q <= sys_rst ? 6'h00 : osc_q + {5'h00, !fault_pin};
  end
  assign osc_clk = osc_q[5];
  // mode: 0 trip, 1 above lower level, 2 over-current, 3 open, 4 cs
  assign cmp = {mode[4], mode[3], mode[0], !mode[1], mode[2]};
endmodule

// ==== tb/tb_led_boost_protection_sequencer.sv ====
`timescale 1ns/10ps
module tb_led_boost_protection_sequencer
  import lbps_pkg::*;
;
  logic              clk, sys_rst, clk_en, osc_clk, pwm_dim_input;
  logic              reg_wr, reg_rd, irq_q, boost_gate_q, dim_gate_q;
  logic              ea_connect_q, fault_output_q, fault_output_oe_q;
  lbps_cmp_t         cmp_in;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata_q;
  logic [4:0]        mode;
  int                fails = 0, samples_checked = 0, cyc = 0;
  wire               fault_pin = fault_output_oe_q ? fault_output_q : 1'b1;
  lbps_seq #(.BLANK_OSC(16)) i_lbps_seq (.clk, .sys_rst, .clk_en,
    .osc_clk, .pwm_dim_input, .cmp_in, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_q, .irq_q, .boost_gate_q, .dim_gate_q,
    .ea_connect_q, .fault_output_q, .fault_output_oe_q);
  lbps_stage_model i_lbps_stage_model (.clk, .sys_rst, .fault_pin, .mode,
    .osc_clk, .cmp(cmp_in));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_q, e);
  endtask
  task stim(input logic [4:0] m, input logic d, input int n);
    @(posedge clk);
    mode <= m;
    pwm_dim_input <= d;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task t_regs;
    rd(CTRL_OFS, CTRL_RST);
    rd(MASK_OFS, MASK_RST);
    rd(4'h2, 8'h00);
    wr(MASK_OFS, 8'h0F);
    rd(MASK_OFS, 8'h0F);
  endtask
  task t_freeze;
    @(posedge clk);
    clk_en <= 1'b0;
    wr(MASK_OFS, 8'h03);
    clk_en <= 1'b1;
    rd(MASK_OFS, 8'h0F);
  endtask
  task t_rearm;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1 chk({fault_pin, fault_output_oe_q}, 8'h01);
    rd(LIVE_OFS, 8'h00);
  endtask
  task t_unarmed;
    stim(5'h08, 1'b0, 300);
    rd(LIVE_OFS, 8'h00);
    rd(STAT_OFS, 8'h00);
  endtask
  task t_dim;
    stim(5'h00, 1'b1, 6);
    chk({dim_gate_q, ea_connect_q, fault_output_oe_q}, 8'h07);
    stim(5'h00, 1'b0, 6);
    chk({dim_gate_q, ea_connect_q, fault_output_oe_q}, 8'h01);
  endtask
  task t_ovp;
    stim(5'h03, 1'b1, 8);
    chk({dim_gate_q, boost_gate_q, fault_output_oe_q, irq_q}, 8'h03);
    stim(5'h02, 1'b1, 8);
    chk(dim_gate_q, 8'h00);
    stim(5'h00, 1'b1, 8);
    chk(dim_gate_q, 8'h01);
    rd(STAT_OFS, 8'h01);
    wr(STAT_OFS, 8'h0F);
    rd(STAT_OFS, 8'h00);
  endtask
  task t_cs;
    stim(5'h10, 1'b1, 100);
    rd(STAT_OFS, 8'h08);
    stim(5'h00, 1'b1, 4);
    wr(STAT_OFS, 8'h0F);
  endtask
  task t_ocp;
    stim(5'h04, 1'b1, 60);
    chk({dim_gate_q, boost_gate_q, fault_output_oe_q}, 8'h01);
    stim(5'h00, 1'b1, 7800);
    chk(dim_gate_q, 8'h00);
    stim(5'h00, 1'b1, 600);
    chk(dim_gate_q, 8'h01);
    rd(STAT_OFS, 8'h02);
  endtask
  task t_open;
    stim(5'h08, 1'b1, 260);
    rd(LIVE_OFS, 8'h34);
    stim(5'h08, 1'b0, 5);
    chk({dim_gate_q, fault_output_oe_q}, 8'h03);
    stim(5'h08, 1'b0, 1100);
    chk({fault_pin, fault_output_oe_q}, 8'h02);
  endtask
  task end_of_test;
    $display("checked %0d, fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      end_of_test;
    end
  end
  initial
  begin
    {sys_rst, clk_en, pwm_dim_input, reg_wr, reg_rd} = 5'h18;
    {reg_addr, reg_wdata, mode} = '0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    t_freeze;
    t_unarmed;
    t_dim;
    t_ovp;
    t_cs;
    t_ocp;
    t_open;
    t_rearm;
    end_of_test;
  end
endmodule
bind lbps_seq lbps_seq_asserts #(.BLANK_OSC(BLANK_OSC)) i_lbps_seq_asserts
  (.clk, .sys_rst, .clk_en, .osc_clk, .cmp_in, .boost_gate_q, .dim_gate_q,
   .ea_connect_q, .fault_output_q, .fault_output_oe_q);
